//--- src/rtc_action_scheduler_regs.sv
// Calendar-driven action scheduler with its register file and four parallel schedules.
`default_nettype none
// Notes on behaviour
// - Calendar values are mirrored read-only; host writes there are discarded.
// - The select register picks which schedule 0 to 3 the parameter pages reach.
// - While running, select shows the schedule whose action started last.
// - Run set executes every active schedule at its programmed times.
// - While run is set, all other scheduler registers ignore writes.
// - Next-action register reports minutes to the next repetition or sequence restart when at most 1439.
// - Type register: 0x00 basic (reset), 0x01 selects this scheduler.
// - Only schedules whose active field is 0x01 execute.
// - Start year, month and day are BCD and match the calendar directly.
// - Start hour and minute are BCD 24-hour values matched against the calendar.
// - Duration gives minutes the action stays on before switching off.
// - Repetition gives minutes between starts; zero means no repetition.
// - Multiplier counts actions per sequence; one gives a single action.
// - Sequence repetition in hours restarts the whole sequence.
// - Host power flag 0x01 switches host on at start, off after duration.
// - Actions start and stop on the calendar minute change.
// - Four schedules run independently in parallel.
module rtc_action_scheduler_regs (
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  input  wire logic                          LINK_CLK,
  input  wire logic                          LINK_REQ,
  input  wire logic                          LINK_WR,
  input  wire logic [sched_pkg::BYTE_W-1:0]  LINK_PAGE,
  input  wire logic [sched_pkg::BYTE_W-1:0]  LINK_REG,
  input  wire logic [sched_pkg::BYTE_W-1:0]  LINK_WDATA,
  output logic      [sched_pkg::BYTE_W-1:0]  LINK_RDATA,
  output logic                               LINK_BUSY,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_SEC,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_MIN,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_HOUR,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_MDAY,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_MONTH,
  input  wire logic [sched_pkg::BYTE_W-1:0]  RTC_YEAR,
  output logic                               HOST_POWER,
  output logic                               RELAY_SET
);
  import sched_pkg::*;

  reg_xfer_if xfer ();

  reg_link u_link (
    .link_clk (LINK_CLK),
    .rst      (RESET),
    .req      (LINK_REQ),
    .wr       (LINK_WR),
    .page     (LINK_PAGE),
    .reg_ofs  (LINK_REG),
    .wdata    (LINK_WDATA),
    .rdata    (LINK_RDATA),
    .busy     (LINK_BUSY),
    .xfer     (xfer.link)
  );

  logic             req_s1_ff;
  logic             req_s2_ff;
  logic             req_seen_ff;
  logic             nxt_req_seen;
  logic             ack_ff;
  logic             nxt_ack;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic [IDX_W-1:0] select_ff;
  logic [IDX_W-1:0] nxt_select;
  logic [7:0]       run_ff;
  logic [7:0]       nxt_run;
  logic [7:0]       type_ff;
  logic [7:0]       nxt_type;
  logic [15:0]      next_min_ff;
  logic [15:0]      nxt_next_min;
  logic             host_ff;
  logic             nxt_host;
  logic             relay_ff;
  logic             nxt_relay;
  logic [7:0]       min_prev_ff;
  sched_cfg_t       cfg_ff  [NUM_SCHED];
  sched_cfg_t       nxt_cfg [NUM_SCHED];

  sched_state_t     st_ff       [NUM_SCHED];
  sched_state_t     nxt_st      [NUM_SCHED];
  logic [13:0]      seq_min_ff  [NUM_SCHED];
  logic [13:0]      nxt_seq_min [NUM_SCHED];
  logic [7:0]       rep_cnt_ff  [NUM_SCHED];
  logic [7:0]       nxt_rep_cnt [NUM_SCHED];
  logic [7:0]       dur_cnt_ff  [NUM_SCHED];
  logic [7:0]       nxt_dur_cnt [NUM_SCHED];
  logic [7:0]       act_cnt_ff  [NUM_SCHED];
  logic [7:0]       nxt_act_cnt [NUM_SCHED];
  logic             on_ff       [NUM_SCHED];
  logic             nxt_on      [NUM_SCHED];
  logic             started     [NUM_SCHED];
  logic [15:0]      sched_next  [NUM_SCHED];

  logic             access;
  logic             locked;
  logic             engine_on;
  logic             tick;
  logic             any_start;
  logic [IDX_W-1:0] start_idx;
  logic [4:0]       slot;
  logic [15:0]      best;

  assign xfer.ack_tgl = ack_ff;
  assign xfer.rdata   = rdata_ff;
  assign HOST_POWER   = host_ff;
  assign RELAY_SET    = relay_ff;

  assign access    = (req_s2_ff != req_seen_ff);
  assign locked    = (run_ff != BYTE_ZERO);
  assign engine_on = (run_ff == FLAG_ON) && (type_ff == TYPE_EVENT);
  assign tick      = (RTC_MIN != min_prev_ff);

  // Maps a parameter page and offset to a byte slot of one schedule; the top bit marks a hit.
  function automatic logic [4:0] cfg_slot(input logic [7:0] page, input logic [7:0] ofs);
    logic [4:0] s;
    s = 5'h00;
    case (page)
      PAGE_START:  if (ofs <= START_LAST) s = {1'b1, ofs[3:0]};
      PAGE_TIMING: if (ofs <= TIMING_LAST) s = {1'b1, TIMING_BASE + ofs[3:0]};
      PAGE_ACTION: if (ofs <= ACTION_LAST) s = {1'b1, ACTION_BASE + ofs[3:0]};
      default:     s = 5'h00;
    endcase
    return s;
  endfunction

  // Register access decode, write protection and the select overwrite.
  always_comb begin
    nxt_req_seen = req_seen_ff;
    nxt_ack      = ack_ff;
    nxt_rdata    = rdata_ff;
    nxt_select   = select_ff;
    nxt_run      = run_ff;
    nxt_type     = type_ff;
    for (int i = 0; i < NUM_SCHED; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    slot = cfg_slot(xfer.page, xfer.reg_ofs);
    if (access) begin
      nxt_req_seen = req_s2_ff;
      nxt_ack      = ~ack_ff;
      nxt_rdata    = BYTE_ZERO;
      case (xfer.page)
        PAGE_RTC: begin
          case (xfer.reg_ofs)
            RTC_SEC_OFS:  nxt_rdata = RTC_SEC;
            RTC_MIN_OFS:  nxt_rdata = RTC_MIN;
            RTC_HOUR_OFS: nxt_rdata = RTC_HOUR;
            RTC_MDAY_OFS: nxt_rdata = RTC_MDAY;
            RTC_MON_OFS:  nxt_rdata = RTC_MONTH;
            RTC_YEAR_OFS: nxt_rdata = RTC_YEAR;
            default:      nxt_rdata = BYTE_ZERO;
          endcase
        end
        PAGE_CTRL: begin
          case (xfer.reg_ofs)
            REG_SELECT:  nxt_rdata = {6'h00, select_ff};
            REG_RUN:     nxt_rdata = run_ff;
            REG_NEXT_LO: nxt_rdata = next_min_ff[7:0];
            REG_NEXT_HI: nxt_rdata = next_min_ff[15:8];
            REG_TYPE:    nxt_rdata = type_ff;
            default:     nxt_rdata = BYTE_ZERO;
          endcase
          if (xfer.wr) begin
            if (xfer.reg_ofs == REG_RUN) begin
              nxt_run = xfer.wdata;
            end
            if (!locked && xfer.reg_ofs == REG_SELECT && xfer.wdata[7:IDX_W] == 6'h00) begin
              nxt_select = xfer.wdata[IDX_W-1:0];
            end
            if (!locked && xfer.reg_ofs == REG_TYPE) begin
              nxt_type = xfer.wdata;
            end
          end
        end
        default: begin
          if (slot[4]) begin
            nxt_rdata = cfg_ff[select_ff][slot[3:0]];
            if (xfer.wr && !locked) begin
              nxt_cfg[select_ff][slot[3:0]] = xfer.wdata;
            end
          end
        end
      endcase
    end
    if (engine_on && any_start) begin
      nxt_select = start_idx;
    end
  end

  // One engine per schedule, all stepping on the same minute change.
  for (genvar g = 0; g < NUM_SCHED; g++) begin : g_sched
    logic [7:0]  mult_eff;
    logic [13:0] period;
    logic [13:0] left;
    logic        hit;
    logic        more;

    always_comb begin
      mult_eff = (cfg_ff[g][CFG_MULT] == BYTE_ZERO) ? BYTE_ONE : cfg_ff[g][CFG_MULT];
      period   = {6'h00, cfg_ff[g][CFG_SEQH]} * MIN_PER_HOUR;
      left     = period - seq_min_ff[g];
      hit      = (cfg_ff[g][CFG_YEAR] == RTC_YEAR) && (cfg_ff[g][CFG_MONTH] == RTC_MONTH)
              && (cfg_ff[g][CFG_MDAY] == RTC_MDAY)
              && (cfg_ff[g][CFG_HOUR] == RTC_HOUR) && (cfg_ff[g][CFG_MIN] == RTC_MIN);
      more     = (act_cnt_ff[g] < mult_eff) && (cfg_ff[g][CFG_REP] != BYTE_ZERO);
      nxt_st[g]      = st_ff[g];
      nxt_seq_min[g] = seq_min_ff[g];
      nxt_rep_cnt[g] = rep_cnt_ff[g];
      nxt_dur_cnt[g] = dur_cnt_ff[g];
      nxt_act_cnt[g] = act_cnt_ff[g];
      nxt_on[g]      = on_ff[g];
      started[g]     = 1'b0;
      sched_next[g]  = NEXT_NONE;
      case (st_ff[g])
        SS_IDLE: begin
          if (engine_on && cfg_ff[g][CFG_ACTIVE] == FLAG_ON) begin
            nxt_st[g] = SS_WAIT;
          end
        end
        SS_WAIT: begin
          if (!engine_on) begin
            nxt_st[g] = SS_IDLE;
          end else if (tick && hit) begin
            started[g]     = 1'b1;
            nxt_st[g]      = SS_RUN;
            nxt_seq_min[g] = SEQ_MIN_ZERO;
            nxt_act_cnt[g] = BYTE_ONE;
            nxt_rep_cnt[g] = cfg_ff[g][CFG_REP];
            nxt_dur_cnt[g] = cfg_ff[g][CFG_DUR];
            nxt_on[g]      = (cfg_ff[g][CFG_DUR] != BYTE_ZERO);
          end
        end
        SS_RUN: begin
          if (more) begin
            sched_next[g] = {8'h00, rep_cnt_ff[g]};
          end
          if (cfg_ff[g][CFG_SEQH] != BYTE_ZERO && {2'b00, left} < sched_next[g]) begin
            sched_next[g] = {2'b00, left};
          end
          if (!engine_on) begin
            nxt_st[g] = SS_IDLE;
            nxt_on[g] = 1'b0;
          end else if (tick) begin
            nxt_seq_min[g] = seq_min_ff[g] + 14'h0001;
            if (on_ff[g]) begin
              nxt_dur_cnt[g] = dur_cnt_ff[g] - BYTE_ONE;
              if (dur_cnt_ff[g] == BYTE_ONE) begin
                nxt_on[g] = 1'b0;
              end
            end
            if (more) begin
              nxt_rep_cnt[g] = rep_cnt_ff[g] - BYTE_ONE;
            end
            if (cfg_ff[g][CFG_SEQH] != BYTE_ZERO && nxt_seq_min[g] == period) begin
              started[g]     = 1'b1;
              nxt_seq_min[g] = SEQ_MIN_ZERO;
              nxt_act_cnt[g] = BYTE_ONE;
              nxt_rep_cnt[g] = cfg_ff[g][CFG_REP];
              nxt_dur_cnt[g] = cfg_ff[g][CFG_DUR];
              nxt_on[g]      = (cfg_ff[g][CFG_DUR] != BYTE_ZERO);
            end else if (more && rep_cnt_ff[g] == BYTE_ONE) begin
              started[g]     = 1'b1;
              nxt_act_cnt[g] = act_cnt_ff[g] + BYTE_ONE;
              nxt_rep_cnt[g] = cfg_ff[g][CFG_REP];
              nxt_dur_cnt[g] = cfg_ff[g][CFG_DUR];
              nxt_on[g]      = (cfg_ff[g][CFG_DUR] != BYTE_ZERO);
            end else if (!more && cfg_ff[g][CFG_SEQH] == BYTE_ZERO && !nxt_on[g]) begin
              nxt_st[g] = SS_DONE;
            end
          end
        end
        SS_DONE: begin
          if (!engine_on) begin
            nxt_st[g] = SS_IDLE;
          end
        end
        default: nxt_st[g] = SS_IDLE;
      endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
        st_ff[g]      <= SS_IDLE;
        seq_min_ff[g] <= SEQ_MIN_ZERO;
        rep_cnt_ff[g] <= BYTE_ZERO;
        dur_cnt_ff[g] <= BYTE_ZERO;
        act_cnt_ff[g] <= BYTE_ZERO;
        on_ff[g]      <= 1'b0;
      end else begin
        st_ff[g]      <= nxt_st[g];
        seq_min_ff[g] <= nxt_seq_min[g];
        rep_cnt_ff[g] <= nxt_rep_cnt[g];
        dur_cnt_ff[g] <= nxt_dur_cnt[g];
        act_cnt_ff[g] <= nxt_act_cnt[g];
        on_ff[g]      <= nxt_on[g];
      end
    end
  end

  // Merges the schedules into the outputs, the next-action time and the executing index.
  always_comb begin
    best      = NEXT_NONE;
    any_start = 1'b0;
    start_idx = select_ff;
    nxt_host  = 1'b0;
    nxt_relay = 1'b0;
    for (int i = 0; i < NUM_SCHED; i++) begin
      if (sched_next[i] < best) begin
        best = sched_next[i];
      end
      if (started[i]) begin
        any_start = 1'b1;
        start_idx = IDX_W'(i);
      end
      if (nxt_on[i] && cfg_ff[i][CFG_HOST] == FLAG_ON) begin
        nxt_host = 1'b1;
      end
      if (nxt_on[i] && cfg_ff[i][CFG_RELAY] == FLAG_ON) begin
        nxt_relay = 1'b1;
      end
    end
    nxt_next_min = (best <= NEXT_LIMIT) ? best : NEXT_NONE;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      req_s1_ff   <= 1'b0;
      req_s2_ff   <= 1'b0;
      req_seen_ff <= 1'b0;
      ack_ff      <= 1'b0;
      rdata_ff    <= BYTE_ZERO;
      select_ff   <= '0;
      run_ff      <= BYTE_ZERO;
      type_ff     <= TYPE_BASIC;
      next_min_ff <= NEXT_NONE;
      host_ff     <= 1'b0;
      relay_ff    <= 1'b0;
      min_prev_ff <= BYTE_ZERO;
      for (int i = 0; i < NUM_SCHED; i++) begin
        cfg_ff[i] <= '0;
      end
    end else begin
      req_s1_ff   <= xfer.req_tgl;
      req_s2_ff   <= req_s1_ff;
      req_seen_ff <= nxt_req_seen;
      ack_ff      <= nxt_ack;
      rdata_ff    <= nxt_rdata;
      select_ff   <= nxt_select;
      run_ff      <= nxt_run;
      type_ff     <= nxt_type;
      next_min_ff <= nxt_next_min;
      host_ff     <= nxt_host;
      relay_ff    <= nxt_relay;
      min_prev_ff <= RTC_MIN;
      for (int i = 0; i < NUM_SCHED; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- pkg/sched_pkg.sv
// Package with register map, field slots, states and timing constants of the action scheduler.
`default_nettype none
package sched_pkg;
  localparam int             BYTE_W       = 8;
  localparam int             NUM_SCHED    = 4;
  localparam int             IDX_W        = 2;
  localparam int             CFG_BYTES    = 12;

  localparam logic [7:0]     BYTE_ZERO    = 8'h00;
  localparam logic [7:0]     BYTE_ONE     = 8'h01;
  localparam logic [7:0]     FLAG_ON      = 8'h01;
  localparam logic [7:0]     TYPE_BASIC   = 8'h00;
  localparam logic [7:0]     TYPE_EVENT   = 8'h01;

  localparam logic [7:0]     PAGE_RTC     = 8'h6A;
  localparam logic [7:0]     PAGE_CTRL    = 8'h6B;
  localparam logic [7:0]     PAGE_START   = 8'h6C;
  localparam logic [7:0]     PAGE_TIMING  = 8'h6D;
  localparam logic [7:0]     PAGE_ACTION  = 8'h6E;

  localparam logic [7:0]     REG_SELECT   = 8'h16;
  localparam logic [7:0]     REG_RUN      = 8'h17;
  localparam logic [7:0]     REG_NEXT_LO  = 8'h18;
  localparam logic [7:0]     REG_TYPE     = 8'h19;
  localparam logic [7:0]     REG_NEXT_HI  = 8'h1A;

  localparam logic [7:0]     RTC_SEC_OFS  = 8'h00;
  localparam logic [7:0]     RTC_MIN_OFS  = 8'h01;
  localparam logic [7:0]     RTC_HOUR_OFS = 8'h02;
  localparam logic [7:0]     RTC_MDAY_OFS = 8'h03;
  localparam logic [7:0]     RTC_MON_OFS  = 8'h04;
  localparam logic [7:0]     RTC_YEAR_OFS = 8'h05;

  localparam logic [7:0]     START_LAST   = 8'h05;
  localparam logic [7:0]     TIMING_LAST  = 8'h03;
  localparam logic [7:0]     ACTION_LAST  = 8'h01;
  localparam logic [3:0]     TIMING_BASE  = 4'h6;
  localparam logic [3:0]     ACTION_BASE  = 4'hA;

  localparam int             CFG_ACTIVE   = 0;
  localparam int             CFG_YEAR     = 1;
  localparam int             CFG_MONTH    = 2;
  localparam int             CFG_MDAY     = 3;
  localparam int             CFG_HOUR     = 4;
  localparam int             CFG_MIN      = 5;
  localparam int             CFG_DUR      = 6;
  localparam int             CFG_REP      = 7;
  localparam int             CFG_MULT     = 8;
  localparam int             CFG_SEQH     = 9;
  localparam int             CFG_HOST     = 10;
  localparam int             CFG_RELAY    = 11;

  localparam logic [13:0]    MIN_PER_HOUR = 14'h003C;
  localparam logic [13:0]    SEQ_MIN_ZERO = 14'h0000;
  localparam logic [15:0]    NEXT_LIMIT   = 16'h059F;
  localparam logic [15:0]    NEXT_NONE    = 16'hFFFF;

  typedef logic [CFG_BYTES-1:0][BYTE_W-1:0] sched_cfg_t;

  typedef enum logic [3:0] {
    SS_IDLE = 4'h1,
    SS_WAIT = 4'h2,
    SS_RUN  = 4'h4,
    SS_DONE = 4'h8
  } sched_state_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'h1,
    LK_WAIT = 2'h2
  } link_state_t;
endpackage
`default_nettype wire

//--- pkg/reg_xfer_if.sv
// Interface carrying one register access between the link clock domain and the core clock domain.
`default_nettype none
interface reg_xfer_if;
  logic       req_tgl;
  logic       ack_tgl;
  logic       wr;
  logic [7:0] page;
  logic [7:0] reg_ofs;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport link (output req_tgl, output wr, output page, output reg_ofs, output wdata,
                input ack_tgl, input rdata);
  modport core (input req_tgl, input wr, input page, input reg_ofs, input wdata,
                output ack_tgl, output rdata);
endinterface
`default_nettype wire

//--- src/reg_link.sv
// Link side of the register access path, running on the link clock.
`default_nettype none
module reg_link
  import sched_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [7:0] page,
  input  wire logic [7:0] reg_ofs,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            busy,
  reg_xfer_if.link        xfer
);
  link_state_t st_ff;
  link_state_t nxt_st;
  logic        req_tgl_ff;
  logic        nxt_req_tgl;
  logic        wr_ff;
  logic        nxt_wr;
  logic [7:0]  page_ff;
  logic [7:0]  nxt_page;
  logic [7:0]  ofs_ff;
  logic [7:0]  nxt_ofs;
  logic [7:0]  wdata_ff;
  logic [7:0]  nxt_wdata;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        busy_ff;
  logic        nxt_busy;
  logic        ack_s1_ff;
  logic        ack_s2_ff;
  logic        ack_seen_ff;
  logic        nxt_ack_seen;

  assign xfer.req_tgl = req_tgl_ff;
  assign xfer.wr      = wr_ff;
  assign xfer.page    = page_ff;
  assign xfer.reg_ofs = ofs_ff;
  assign xfer.wdata   = wdata_ff;
  assign rdata        = rdata_ff;
  assign busy         = busy_ff;

  // A request is latched and held stable until the core answers; requests while busy are dropped.
  always_comb begin
    nxt_st       = st_ff;
    nxt_req_tgl  = req_tgl_ff;
    nxt_wr       = wr_ff;
    nxt_page     = page_ff;
    nxt_ofs      = ofs_ff;
    nxt_wdata    = wdata_ff;
    nxt_rdata    = rdata_ff;
    nxt_busy     = busy_ff;
    nxt_ack_seen = ack_seen_ff;
    case (st_ff)
      LK_IDLE: begin
        if (req) begin
          nxt_wr      = wr;
          nxt_page    = page;
          nxt_ofs     = reg_ofs;
          nxt_wdata   = wdata;
          nxt_req_tgl = ~req_tgl_ff;
          nxt_busy    = 1'b1;
          nxt_st      = LK_WAIT;
        end
      end
      LK_WAIT: begin
        if (ack_s2_ff != ack_seen_ff) begin
          nxt_ack_seen = ack_s2_ff;
          nxt_rdata    = xfer.rdata;
          nxt_busy     = 1'b0;
          nxt_st       = LK_IDLE;
        end
      end
      default: nxt_st = LK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_ff       <= LK_IDLE;
      req_tgl_ff  <= 1'b0;
      wr_ff       <= 1'b0;
      page_ff     <= BYTE_ZERO;
      ofs_ff      <= BYTE_ZERO;
      wdata_ff    <= BYTE_ZERO;
      rdata_ff    <= BYTE_ZERO;
      busy_ff     <= 1'b0;
      ack_s1_ff   <= 1'b0;
      ack_s2_ff   <= 1'b0;
      ack_seen_ff <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      req_tgl_ff  <= nxt_req_tgl;
      wr_ff       <= nxt_wr;
      page_ff     <= nxt_page;
      ofs_ff      <= nxt_ofs;
      wdata_ff    <= nxt_wdata;
      rdata_ff    <= nxt_rdata;
      busy_ff     <= nxt_busy;
      ack_s1_ff   <= xfer.ack_tgl;
      ack_s2_ff   <= ack_s1_ff;
      ack_seen_ff <= nxt_ack_seen;
    end
  end
endmodule
`default_nettype wire

//--- verification/sched_props.sv
// Checker of the scheduler's port timing.
`default_nettype none
module sched_props (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       LINK_CLK,
  input wire logic       LINK_REQ,
  input wire logic       LINK_BUSY,
  input wire logic [7:0] LINK_RDATA,
  input wire logic [7:0] RTC_MIN,
  input wire logic       HOST_POWER,
  input wire logic       RELAY_SET
);
  timeunit 1ns;
  timeprecision 1ps;
  host_rise_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(HOST_POWER) |-> $past(RTC_MIN, 1) != $past(RTC_MIN, 2)) else $error("host power rose off the tick");
  relay_rise_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(RELAY_SET) |-> $past(RTC_MIN, 1) != $past(RTC_MIN, 2)) else $error("relay rose off the tick");
  host_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(HOST_POWER) |=> HOST_POWER[*3]) else $error("host power pulse too short");
  reset_quiet_a: assert property (@(posedge CLK) disable iff (RESET)
    $fell(RESET) |-> !HOST_POWER && !RELAY_SET) else $error("outputs active after reset");
  busy_take_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
    LINK_REQ && !LINK_BUSY |=> LINK_BUSY) else $error("request not taken");
  busy_bound_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
    $rose(LINK_BUSY) |-> ##[1:60] !LINK_BUSY) else $error("access never answered");
  busy_cause_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
    $rose(LINK_BUSY) |-> $past(LINK_REQ)) else $error("busy without request");
  rdata_hold_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
    !$fell(LINK_BUSY) |-> $stable(LINK_RDATA)) else $error("read data moved between answers");
  cover property (@(posedge CLK) disable iff (RESET) $rose(HOST_POWER));
  cover property (@(posedge CLK) disable iff (RESET) $fell(RELAY_SET));
  cover property (@(posedge LINK_CLK) disable iff (RESET) $fell(LINK_BUSY));
endmodule
`default_nettype wire

//--- verification/host_model.sv
// Host model issuing single-byte register accesses on the link clock.
`default_nettype none
module host_model (
  input  wire logic       link_clk,
  input  wire logic       busy,
  input  wire logic [7:0] rdata,
  output logic            req,
  output logic            wr,
  output logic [7:0]      page,
  output logic [7:0]      ofs,
  output logic [7:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req = 1'b0;
    wr = 1'b0;
    page = 8'h00;
    ofs = 8'h00;
    wdata = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] p, input logic [7:0] r, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    @(negedge link_clk);
    req = 1'b1;
    wr = w;
    page = p;
    ofs = r;
    wdata = d;
    @(negedge link_clk);
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge link_clk);
      n++;
    end
    q = (n < 100) ? rdata : 8'hXX;
    // Released qualifiers no longer show the last value.
    page = ~p;
    ofs = ~r;
    wdata = ~d;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_rtc_action_scheduler_regs.sv
// Testbench of the calendar-driven action scheduler.
`default_nettype none
module tb_rtc_action_scheduler_regs import sched_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] p; logic [7:0] r; logic [7:0] w; logic [7:0] e;} row_t;
  logic       clk = 1'b0, link_clk = 1'b0, reset = 1'b1, req, wr, busy, host, relay;
  logic [7:0] page, ofs, wdata, rdata, q, min = 8'h59, hour = 8'h09, year = 8'h17;
  int         err_count = 0, total_checks = 0;
  row_t       rows[20] = '{'{8'h6B, 8'h18, 8'h00, 8'hFF}, '{8'h6B, 8'h16, 8'h02, 8'h02}, '{8'h6B, 8'h16, 8'h05, 8'h02},
    '{8'h6A, 8'h05, 8'h00, 8'h17}, '{8'h6B, 8'h1A, 8'h00, 8'hFF},
    '{8'h6B, 8'h19, 8'h01, 8'h01}, '{8'h6C, 8'h00, 8'h01, 8'h01}, '{8'h6C, 8'h01, 8'h17, 8'h17},
    '{8'h6C, 8'h02, 8'h08, 8'h08}, '{8'h6C, 8'h03, 8'h20, 8'h20}, '{8'h6C, 8'h04, 8'h10, 8'h10},
    '{8'h6C, 8'h05, 8'h00, 8'h00}, '{8'h6D, 8'h00, 8'h02, 8'h02}, '{8'h6D, 8'h01, 8'h03, 8'h03},
    '{8'h6D, 8'h02, 8'h02, 8'h02}, '{8'h6D, 8'h03, 8'h00, 8'h00}, '{8'h6E, 8'h00, 8'h01, 8'h01},
    '{8'h6E, 8'h01, 8'h01, 8'h01}, '{8'h6A, 8'h01, 8'h55, 8'h59}, '{8'h6B, 8'h30, 8'hAA, 8'h00}};
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  host_model u_host (.link_clk(link_clk), .busy(busy), .rdata(rdata), .req(req), .wr(wr), .page(page),
    .ofs(ofs), .wdata(wdata));
  rtc_action_scheduler_regs u_dut (.CLK(clk), .RESET(reset), .LINK_CLK(link_clk), .LINK_REQ(req), .LINK_WR(wr),
    .LINK_PAGE(page), .LINK_REG(ofs), .LINK_WDATA(wdata), .LINK_RDATA(rdata), .LINK_BUSY(busy), .RTC_SEC(8'h00),
    .RTC_MIN(min), .RTC_HOUR(hour), .RTC_MDAY(8'h20), .RTC_MONTH(8'h08), .RTC_YEAR(year), .HOST_POWER(host),
    .RELAY_SET(relay));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input logic [7:0] h, input logic [7:0] m);
    @(negedge clk);
    hour = h;
    min = m;
    repeat (3) @(negedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    u_host.access(1'b0, PAGE_CTRL, REG_TYPE, 8'h00, q);
    check(q, TYPE_BASIC);
    for (int i = 0; i < 20; i++) begin
      u_host.access(1'b1, rows[i].p, rows[i].r, rows[i].w, q);
      u_host.access(1'b0, rows[i].p, rows[i].r, 8'h00, q);
      check(q, rows[i].e);
    end
    $display("register table done");
    u_host.access(1'b1, PAGE_CTRL, REG_RUN, BYTE_ONE, q);
    tick(8'h10, 8'h00);
    check({6'h00, host, relay}, 8'h03);
    u_host.access(1'b0, PAGE_CTRL, REG_SELECT, 8'h00, q);
    check(q, 8'h02);
    u_host.access(1'b1, PAGE_CTRL, REG_SELECT, 8'h01, q);
    u_host.access(1'b0, PAGE_CTRL, REG_SELECT, 8'h00, q);
    check(q, 8'h02);
    u_host.access(1'b0, PAGE_CTRL, REG_NEXT_LO, 8'h00, q);
    check(q, 8'h03);
    for (int i = 1; i < 7; i++) begin
      tick(8'h10, 8'(i));
      check({6'h00, host, relay}, (((6'b001101 >> (i - 1)) & 6'h01) != 6'h00) ? 8'h03 : 8'h00);
    end
    u_host.access(1'b1, PAGE_TIMING, 8'h00, 8'h07, q);
    u_host.access(1'b0, PAGE_TIMING, 8'h00, 8'h00, q);
    check(q, 8'h02);
    $display("schedule run done");
    u_host.access(1'b1, PAGE_CTRL, REG_RUN, BYTE_ZERO, q);
    u_host.access(1'b1, PAGE_CTRL, REG_SELECT, 8'h03, q);
    u_host.access(1'b0, PAGE_CTRL, REG_SELECT, 8'h00, q);
    check(q, 8'h03);
    $display("unlock done");
    u_host.access(1'b1, PAGE_CTRL, REG_RUN, BYTE_ONE, q);
    @(negedge clk);
    year = 8'h18;
    tick(8'h10, 8'h00);
    check({6'h00, host, relay}, 8'h00);
    year = 8'h17;
    tick(8'h10, 8'h01);
    tick(8'h10, 8'h00);
    check({6'h00, host, relay}, 8'h03);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check({6'h00, host, relay}, 8'h00);
    reset = 1'b0;
    u_host.access(1'b0, PAGE_CTRL, REG_RUN, 8'h00, q);
    check(q, BYTE_ZERO);
    u_host.access(1'b0, PAGE_CTRL, REG_TYPE, 8'h00, q);
    check(q, TYPE_BASIC);
    u_host.access(1'b0, PAGE_CTRL, REG_SELECT, 8'h00, q);
    check(q, 8'h00);
    u_host.access(1'b0, PAGE_START, 8'h00, 8'h00, q);
    check(q, BYTE_ZERO);
    $display("reset done");
    complete_run();
  end
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule
bind rtc_action_scheduler_regs sched_props u_props (.CLK(CLK), .RESET(RESET), .LINK_CLK(LINK_CLK),
  .LINK_REQ(LINK_REQ), .LINK_BUSY(LINK_BUSY), .LINK_RDATA(LINK_RDATA), .RTC_MIN(RTC_MIN),
  .HOST_POWER(HOST_POWER), .RELAY_SET(RELAY_SET));
`default_nettype wire
